// *** aioctl_map.svh ***
`ifndef AIOCTL_MAP_SVH
`define AIOCTL_MAP_SVH

// ----------------------------------------
// device selection and register indices
// ----------------------------------------
`define AIOCTL_DEV_NUM 8'h09
`define AIOCTL_REG_IN_CTRL 3'h0
`define AIOCTL_REG_IN_STAT 3'h0
`define AIOCTL_REG_OUT_CHAN 3'h1
`define AIOCTL_REG_IN_RESULT 3'h2
`define AIOCTL_REG_OUT_VALUE 3'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define AIOCTL_BIT_START 0
`define AIOCTL_BIT_SHORT 1
`define AIOCTL_BIT_EOC_EN 2
`define AIOCTL_BIT_BUSY 0
`define AIOCTL_BIT_DONE 1
`define AIOCTL_BIT_EN_RB 2
`define AIOCTL_CHAN_LSB 8
`define AIOCTL_CHAN_MSB 15
`define AIOCTL_CONV_MSB 11
`define AIOCTL_HI_LSB 12
`define AIOCTL_DAC_CH0 8'h00
`define AIOCTL_DAC_CH1 8'h01

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define AIOCTL_RST_WORD 16'h0000
`define AIOCTL_RST_CHAN 8'h00
`define AIOCTL_RST_CONV 12'h000
`define AIOCTL_CONV_BITS 4
`define AIOCTL_HI_ZERO 4'h0
`define AIOCTL_OUT_CHANNELS 2

`endif

// *** aioctl_pkg.sv ***
package aioctl_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    AIOCTL_IDLE = 2'b00,
    AIOCTL_CONV = 2'b01,
    AIOCTL_DONE = 2'b11
  } aioctl_state_type;

  typedef struct packed
  {
    logic [7:0] channel;
    logic [4:0] unused_hi;
    logic eoc_enable;
    logic short_cycle;
    logic start;
  } aioctl_in_ctrl_type;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [2:0] index;
    logic [15:0] wdata;
  } aioctl_access_type;

endpackage

// *** aioctl_top.sv ***
// Functional notes
// R01 - set start bit begins a conversion
// R02 - short-cycle bit reserved, no function
// R03 - enable bit gates end-of-conversion interrupt
// R04 - bits 8-15 pick input channel
// R05 - status bit 0 shows busy
// R06 - status bit 1 shows conversion finished
// R07 - status bit 2 echoes interrupt enable
// R08 - result holds 12 bits, upper zero
// R09 - software reads result only when idle
// R10 - select channel, wait 20 us, then start
// R11 - clear start bit to read result
// R12 - software clears enable after servicing
// R13 - select a channel once for repeats
// R14 - output unit shares device number nine
// R15 - output control reg 1, value reg 3
// R16 - bits 8-15 pick output channel
// R17 - value write drives chosen 12-bit dac
// R18 - select device, channel, then value
// R19 - same layout serves wider expansion units
// R20 - input regs at device register 0, 2
// R21 - registers map only when device selected
// R22 - rising start sets busy, result clears it
`timescale 1ns/10ps
`include "aioctl_map.svh"

module aioctl_top
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] device_number,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_index,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rsel,
  output logic [7:0] adc_channel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic end_conv_irq,
  output logic [11:0] dac_value_0,
  output logic [11:0] dac_value_1,
  output logic [7:0] dac_channel
);

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  aioctl_pkg::aioctl_access_type acc;
  aioctl_pkg::aioctl_in_ctrl_type in_ctrl_q;
  aioctl_pkg::aioctl_state_type state_q;
  logic [11:0] result_q;
  logic [11:0] conv_q;
  logic [7:0] out_chan_q;
  logic start_prev_q;
  logic sel;

  function automatic logic hit(input logic [2:0] idx, input logic [2:0] want);
    hit = (idx == want);
  endfunction

  // write and read strobes aimed at one register of this unit
  function automatic logic wr_to(input aioctl_pkg::aioctl_access_type a, input logic s,
    input logic [2:0] want);
    wr_to = s && a.wr && hit(a.index, want);
  endfunction

  function automatic logic rd_to(input aioctl_pkg::aioctl_access_type a, input logic s,
    input logic [2:0] want);
    rd_to = s && a.rd && hit(a.index, want);
  endfunction

  assign acc = '{wr: reg_wr, rd: reg_rd, index: reg_index, wdata: reg_wdata};
  assign sel = (device_number == `AIOCTL_DEV_NUM); // R21 R14 R19

  // ----------------------------------------
  // input control register
  // ----------------------------------------
  // short-cycle bit is forced to zero on every write and drives nothing
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      in_ctrl_q <= `AIOCTL_RST_WORD;
    else if (wr_to(acc, sel, `AIOCTL_REG_IN_CTRL)) // R20
    begin
      in_ctrl_q <= acc.wdata; // R04 R02
      in_ctrl_q.short_cycle <= 1'b0; // R02
    end
  end

  assign adc_channel = in_ctrl_q.channel; // R04

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      start_prev_q <= 1'b0;
    else
      start_prev_q <= in_ctrl_q.start;
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  // a start seen while busy is dropped; the converter takes one request at a time
  logic start_rise;
  assign start_rise = in_ctrl_q.start && !start_prev_q; // R22 R01

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= aioctl_pkg::AIOCTL_IDLE;
    else
    begin
      unique case (state_q)
        aioctl_pkg::AIOCTL_IDLE:
          if (start_rise)
            state_q <= aioctl_pkg::AIOCTL_CONV; // R01 R22
        aioctl_pkg::AIOCTL_CONV:
          if (adc_done)
            state_q <= aioctl_pkg::AIOCTL_DONE; // R22
        aioctl_pkg::AIOCTL_DONE:
          if (start_rise)
            state_q <= aioctl_pkg::AIOCTL_CONV; // R01
        default:
          state_q <= aioctl_pkg::AIOCTL_IDLE;
      endcase
    end
  end

  // one-cycle request to the converter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      adc_start <= 1'b0;
    else
      adc_start <= start_rise && (state_q != aioctl_pkg::AIOCTL_CONV); // R01
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      conv_q <= `AIOCTL_RST_CONV;
    else if (state_q == aioctl_pkg::AIOCTL_CONV && adc_done)
      conv_q <= adc_data; // R08
  end

  // result becomes visible only once software drops the start bit
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      result_q <= `AIOCTL_RST_CONV;
    else if (state_q == aioctl_pkg::AIOCTL_DONE && !in_ctrl_q.start)
      result_q <= conv_q; // R11 R09
  end

  assign end_conv_irq = (state_q == aioctl_pkg::AIOCTL_DONE) && in_ctrl_q.eoc_enable; // R03 R06

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // read data is registered so the host sees it one cycle after its strobe
  logic [15:0] rdata_d;
  always_comb
  begin
    rdata_d = `AIOCTL_RST_WORD;
    if (hit(acc.index, `AIOCTL_REG_IN_STAT))
    begin
      rdata_d[`AIOCTL_BIT_BUSY] = (state_q == aioctl_pkg::AIOCTL_CONV); // R05
      rdata_d[`AIOCTL_BIT_DONE] = (state_q == aioctl_pkg::AIOCTL_DONE); // R06
      rdata_d[`AIOCTL_BIT_EN_RB] = in_ctrl_q.eoc_enable; // R07
    end
    else if (hit(acc.index, `AIOCTL_REG_IN_RESULT))
      rdata_d = {`AIOCTL_HI_ZERO, result_q}; // R08 R20
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= `AIOCTL_RST_WORD;
    else if (sel && acc.rd)
      reg_rdata <= rdata_d;
  end

  // select only real registers, so gaps in the map never steer the host bus
  assign reg_rsel = rd_to(acc, sel, `AIOCTL_REG_IN_STAT) ||
    rd_to(acc, sel, `AIOCTL_REG_IN_RESULT);

  // ----------------------------------------
  // analog output unit
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      out_chan_q <= `AIOCTL_RST_CHAN;
    else if (wr_to(acc, sel, `AIOCTL_REG_OUT_CHAN)) // R15
      out_chan_q <= acc.wdata[`AIOCTL_CHAN_MSB:`AIOCTL_CHAN_LSB]; // R16
  end

  assign dac_channel = out_chan_q;

  // channels above 1 are for expansion units; the board ignores them
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dac_value_0 <= `AIOCTL_RST_CONV;
      dac_value_1 <= `AIOCTL_RST_CONV;
    end
    else if (wr_to(acc, sel, `AIOCTL_REG_OUT_VALUE)) // R15
    begin
      if (out_chan_q == `AIOCTL_DAC_CH0)
        dac_value_0 <= acc.wdata[`AIOCTL_CONV_MSB:0]; // R17
      else if (out_chan_q == `AIOCTL_DAC_CH1)
        dac_value_1 <= acc.wdata[`AIOCTL_CONV_MSB:0]; // R17
    end
  end

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // a start accepted while the converter is free
  sequence s_start_taken;
    start_rise && state_q != aioctl_pkg::AIOCTL_CONV;
  endsequence

  // converter request high for exactly one cycle
  sequence s_one_pulse;
    adc_start ##1 !adc_start;
  endsequence

  // converter reports its result while busy
  sequence s_result_in;
    state_q == aioctl_pkg::AIOCTL_CONV && adc_done;
  endsequence

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_start_to_busy: assert property (@(posedge clk) disable iff (!resetn) // R01
    s_start_taken |=> state_q == aioctl_pkg::AIOCTL_CONV)
    else $error("start did not set busy");

  a_start_pulse: assert property (@(posedge clk) disable iff (!resetn) // R22
    s_start_taken |=> s_one_pulse)
    else $error("converter start not one pulse");

  a_irq_gate: assert property (@(posedge clk) disable iff (!resetn) // R03
    state_q == aioctl_pkg::AIOCTL_CONV && adc_done && in_ctrl_q.eoc_enable &&
    !wr_to(acc, sel, `AIOCTL_REG_IN_CTRL) |=> end_conv_irq)
    else $error("no interrupt at end of conversion");

  a_done_ends_busy: assert property (@(posedge clk) disable iff (!resetn) // R06
    s_result_in |=> state_q == aioctl_pkg::AIOCTL_DONE)
    else $error("busy not cleared at result");

  a_result_latch: assert property (@(posedge clk) disable iff (!resetn) // R11
    state_q == aioctl_pkg::AIOCTL_DONE && !in_ctrl_q.start |=> result_q == $past(conv_q))
    else $error("result not released");

  a_status_read: assert property (@(posedge clk) disable iff (!resetn) // R07
    sel && acc.rd && acc.index == `AIOCTL_REG_IN_STAT |=>
    reg_rdata[`AIOCTL_BIT_EN_RB] == $past(in_ctrl_q.eoc_enable))
    else $error("enable readback wrong");

  a_result_read: assert property (@(posedge clk) disable iff (!resetn) // R08
    sel && acc.rd && acc.index == `AIOCTL_REG_IN_RESULT |=>
    reg_rdata[`AIOCTL_CHAN_MSB:`AIOCTL_HI_LSB] == `AIOCTL_HI_ZERO &&
    reg_rdata[`AIOCTL_CONV_MSB:0] == $past(result_q))
    else $error("result read wrong");

  a_dac_write: assert property (@(posedge clk) disable iff (!resetn) // R17
    wr_to(acc, sel, `AIOCTL_REG_OUT_VALUE) && out_chan_q == `AIOCTL_DAC_CH1 |=>
    dac_value_1 == $past(acc.wdata[`AIOCTL_CONV_MSB:0]))
    else $error("dac 1 not written");

  a_unselected: assert property (@(posedge clk) disable iff (!resetn) // R21
    !sel |=> $stable(out_chan_q) && $stable(in_ctrl_q))
    else $error("write while unselected");

  a_conv_capture: assert property (@(posedge clk) disable iff (!resetn) // R08
    s_result_in |=> conv_q == $past(adc_data))
    else $error("converter result not captured");

  a_busy_hold: assert property (@(posedge clk) disable iff (!resetn) // R05
    state_q == aioctl_pkg::AIOCTL_CONV && !adc_done |=> state_q == aioctl_pkg::AIOCTL_CONV)
    else $error("busy dropped before result");

  a_done_hold: assert property (@(posedge clk) disable iff (!resetn) // R06
    state_q == aioctl_pkg::AIOCTL_DONE && !start_rise |=> state_q == aioctl_pkg::AIOCTL_DONE)
    else $error("finished state lost");

  a_no_restart: assert property (@(posedge clk) disable iff (!resetn) // R22
    state_q == aioctl_pkg::AIOCTL_CONV |=> !adc_start)
    else $error("converter restarted while busy");

  a_no_level_start: assert property (@(posedge clk) disable iff (!resetn) // R22
    !start_rise && state_q != aioctl_pkg::AIOCTL_CONV |=>
    state_q != aioctl_pkg::AIOCTL_CONV)
    else $error("conversion without start edge");

  a_irq_restart: assert property (@(posedge clk) disable iff (!resetn) // R03
    state_q == aioctl_pkg::AIOCTL_DONE && start_rise |=> !end_conv_irq)
    else $error("interrupt kept after new start");

  a_ctrl_write: assert property (@(posedge clk) disable iff (!resetn) // R02 R04
    wr_to(acc, sel, `AIOCTL_REG_IN_CTRL) |=> !in_ctrl_q.short_cycle &&
    in_ctrl_q.channel == $past(acc.wdata[`AIOCTL_CHAN_MSB:`AIOCTL_CHAN_LSB]))
    else $error("input control write wrong");

  a_enable_write: assert property (@(posedge clk) disable iff (!resetn) // R03 R07
    wr_to(acc, sel, `AIOCTL_REG_IN_CTRL) |=>
    in_ctrl_q.eoc_enable == $past(acc.wdata[`AIOCTL_BIT_EOC_EN]) &&
    in_ctrl_q.start == $past(acc.wdata[`AIOCTL_BIT_START]))
    else $error("control bits not stored");

  a_chan_write: assert property (@(posedge clk) disable iff (!resetn) // R16
    wr_to(acc, sel, `AIOCTL_REG_OUT_CHAN) |=>
    out_chan_q == $past(acc.wdata[`AIOCTL_CHAN_MSB:`AIOCTL_CHAN_LSB]))
    else $error("output channel not stored");

  a_dac0_write: assert property (@(posedge clk) disable iff (!resetn) // R17
    wr_to(acc, sel, `AIOCTL_REG_OUT_VALUE) && out_chan_q == `AIOCTL_DAC_CH0 |=>
    dac_value_0 == $past(acc.wdata[`AIOCTL_CONV_MSB:0]))
    else $error("dac 0 not written");

  a_far_channel: assert property (@(posedge clk) disable iff (!resetn) // R19
    wr_to(acc, sel, `AIOCTL_REG_OUT_VALUE) && out_chan_q > `AIOCTL_DAC_CH1 |=>
    $stable(dac_value_0) && $stable(dac_value_1))
    else $error("expansion channel hit a board dac");

  a_status_bits: assert property (@(posedge clk) disable iff (!resetn) // R05 R06
    rd_to(acc, sel, `AIOCTL_REG_IN_STAT) |=>
    reg_rdata[`AIOCTL_BIT_BUSY] == ($past(state_q) == aioctl_pkg::AIOCTL_CONV) &&
    reg_rdata[`AIOCTL_BIT_DONE] == ($past(state_q) == aioctl_pkg::AIOCTL_DONE))
    else $error("status bits wrong");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn) // R20
    !(sel && acc.rd) |=> $stable(reg_rdata))
    else $error("read data changed without read");

  a_unsel_hold: assert property (@(posedge clk) disable iff (!resetn) // R21
    !sel |=> $stable(dac_value_0) && $stable(dac_value_1))
    else $error("dac written while unselected");

endmodule

// *** aioctl_top_tb.sv ***
`timescale 1ns/10ps
module aioctl_top_tb;
  logic clk, resetn, reg_wr, reg_rd, adc_done, reg_rsel, adc_start, end_conv_irq, rd_q;
  logic [7:0] device_number, adc_channel, dac_channel;
  logic [2:0] reg_index;
  logic [15:0] reg_wdata, reg_rdata;
  logic [11:0] adc_data, dac_value_0, dac_value_1, e0, e1, v, last_res;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h00000047;
  int miscompares, cmp_count;
  // about 20 us of multiplexer settling at 100 MHz
  localparam int settle_cycles = 2000;

  aioctl_top aioctl_top_inst
  (
    .clk(clk), .resetn(resetn), .device_number(device_number), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rsel(reg_rsel), .adc_channel(adc_channel), .adc_start(adc_start),
    .adc_done(adc_done), .adc_data(adc_data), .end_conv_irq(end_conv_irq),
    .dac_value_0(dac_value_0), .dac_value_1(dac_value_1), .dac_channel(dac_channel)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one idle cycle between accesses, so no strobe is driven twice in a step
  task automatic wr(input logic [2:0] idx, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_index = idx;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
    logic exp_sel;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_index = idx;
    exp_sel = (device_number === 8'h09) && (idx == 3'h0 || idx == 3'h2);
    if (device_number === 8'h09)
      exp_q.push_back(exp);
    #1;
    check("read select", {15'h0000, exp_sel}, {15'h0000, reg_rsel});
    @(negedge clk);
    reg_rd = 1'b0;
  endtask

  // ----------------------------------------
  // read monitor
  // ----------------------------------------
  always @(posedge clk)
    rd_q <= reg_rd && (device_number === 8'h09);

  always @(negedge clk)
    if (rd_q)
    begin
      if (exp_q.size() == 0)
        check("unexpected read", 16'hFFFF, reg_rdata);
      else
        check("read data", exp_q.pop_front(), reg_rdata);
    end

  // ----------------------------------------
  // conversion sequence
  // ----------------------------------------
  task automatic conv(input logic [7:0] ch, input logic en, input logic [11:0] d);
    int i;
    wr(3'h0, {ch, 8'h00});
    check("adc channel", {8'h00, ch}, {8'h00, adc_channel});
    repeat (settle_cycles) @(negedge clk);
    wr(3'h0, {ch, 8'h01});
    for (i = 0; i < 8 && adc_start !== 1'b1; i++)
      @(negedge clk);
    if (adc_start !== 1'b1)
    begin
      check("converter start", 16'h0001, {15'h0000, adc_start});
      return;
    end
    wr(3'h0, {ch, 5'h00, en, 2'b01});
    rd(3'h0, {13'h0000, en, 2'b01});
    @(negedge clk);
    adc_done = 1'b1;
    adc_data = d;
    @(negedge clk);
    adc_done = 1'b0;
    adc_data = ~d;
    check("irq", {15'h0000, en}, {15'h0000, end_conv_irq});
    rd(3'h0, {13'h0000, en, 2'b10});
    rd(3'h2, {4'h0, last_res});
    wr(3'h0, {ch, 5'h00, en, 2'b00});
    rd(3'h2, {4'h0, d});
    last_res = d;
    wr(3'h0, {ch, 8'h00});
    check("irq off", 16'h0000, {15'h0000, end_conv_irq});
    rd(3'h0, 16'h0002);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    resetn = 1'b0;
    {reg_wr, reg_rd, adc_done, reg_index, reg_wdata, adc_data} = '0;
    last_res = 12'h000;
    device_number = 8'h09;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    check("dac reset", 16'h0000, {4'h0, dac_value_0 | dac_value_1});
    rd(3'h5, 16'h0000);
    rd(3'h1, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
      conv(8'(rnd()), k[0], 12'(rnd()));
    $display("test conversion done");
    device_number = 8'h08;
    wr(3'h0, 16'h0105);
    repeat (4)
    begin
      @(negedge clk);
      check("foreign start", 16'h0000, {15'h0000, adc_start});
    end
    rd(3'h0, 16'h0000);
    device_number = 8'h09;
    $display("test foreign device done");
    e0 = 12'h000;
    e1 = 12'h000;
    for (int c = 0; c < 3; c++)
    begin
      v = 12'(rnd());
      wr(3'h1, {c[7:0], 8'h00});
      check("dac channel", {8'h00, c[7:0]}, {8'h00, dac_channel});
      wr(3'h3, {4'h0, v});
      if (c == 0)
        e0 = v;
      if (c == 1)
        e1 = v;
      check("dac 0", {4'h0, e0}, {4'h0, dac_value_0});
      check("dac 1", {4'h0, e1}, {4'h0, dac_value_1});
    end
    $display("test analog output done");
    repeat (3) @(negedge clk);
    give_verdict();
  end
endmodule
